// [cbm_defines.svh]
// constants for the branch timing, address decode and stack record block
// Summary of operation
// - bit-to-carry logic and bit complement: 2 cycles
// - carry branches: 2 cycles, 3 when taken
// - bit branches 3/4; clearing form clears when taken
// - indirect compare 4/5; other compares 3/4
// - decrement branch: direct 3/4, bank register 2/3
// - table jump to acc plus data pointer: 3
// - relative operand: signed 8-bit, from next instruction
// - page target: 11 bits inside next instruction's 2K
// - full target: 16 bits anywhere in 64K
// - unused opcode behaves exactly like no-operation
// - direct low half RAM, upper half special space
// - indirect above 0x7F reaches separate upper RAM
// - flash spans 64K; top region reserved
// - program memory written only while store-enable set
// - bank registers map to bank from status bits 4:3
// - only bank registers 0 and 1 are pointers
// - bit address below 0x80 maps into bytes 0x20..0x2F
// - bit or byte access chosen by instruction type
// - stack pointer marks last used; push pre-increments
// - stack pointer at 0x81 resets to 0x07
// - 32-bit record: push 1, call 2, pops likewise
// - record overflow and underflow flagged to debug
`ifndef CBM_DEFINES_SVH
`define CBM_DEFINES_SVH
`define CBM_SP_ADDR       8'h81
`define CBM_PROGRAM_STORE_CONTROL_ADDR    8'h8f
`define CBM_SP_RESET      8'h07
`define CBM_PROGRAM_STORE_CONTROL_WE_BIT  0
`define CBM_BANK_LO_BIT   3
`define CBM_BANK_HI_BIT   4
`define CBM_BIT_BYTE_BASE 4'h2
`define CBM_RESERVED_BASE 16'hee00
`define CBM_REC_DEPTH     6'd32
`define OP_NOP            8'h00
`define OP_UNUSED         8'ha5
`define OP_CPL_BIT        8'hb2
`define OP_ANL_C_BIT      8'h82
`define OP_ANL_C_NBIT     8'hb0
`define OP_ORL_C_BIT      8'h72
`define OP_ORL_C_NBIT     8'ha0
`define OP_MOV_C_BIT      8'ha2
`define OP_MOV_BIT_C      8'h92
`define OP_JC             8'h40
`define OP_JNC            8'h50
`define OP_JB             8'h20
`define OP_JNB            8'h30
`define OP_JBC            8'h10
`define OP_LONG_CALL          8'h12
`define OP_LONG_JUMP           8'h02
`define OP_RET            8'h22
`define OP_INTERRUPT_RETURN           8'h32
`define OP_SHORT_JUMP           8'h80
`define OP_JMP_IND        8'h73
`define OP_JZ             8'h60
`define OP_JNZ            8'h70
`define OP_COMPARE_BRANCH_UNEQUAL_A_DIR     8'hb5
`define OP_COMPARE_BRANCH_UNEQUAL_A_IMM     8'hb4
`define OP_DECREMENT_BRANCH_NONZERO_DIR       8'hd5
`define OP_PUSH           8'hc0
`define OP_POP            8'hd0
`define OP_ABSOLUTE_CALL_LO       5'h11
`define OP_ABSOLUTE_JUMP_LO        5'h01
`define OP_COMPARE_BRANCH_UNEQUAL_IND_HI    7'h5b
`define OP_COMPARE_BRANCH_UNEQUAL_REG_HI    5'h17
`define OP_DECREMENT_BRANCH_NONZERO_REG_HI    5'h1b
`endif

// [cbm_pkg.sv]
// types shared by the branch timing, address decode and stack record block
package cbm_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} cbm_state_e;
  typedef enum logic [1:0] {
    MODE_DIRECT   = 2'h0,
    MODE_INDIRECT = 2'h1,
    MODE_BIT      = 2'h2,
    MODE_BANKREG  = 2'h3
  } cbm_mode_e;
  typedef enum logic [2:0] {
    RGN_LOWER = 3'b001,
    RGN_UPPER = 3'b010,
    RGN_SFR   = 3'b100
  } cbm_region_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } cbm_instr_s;
  typedef struct packed {
    logic carry;
    logic bit_val;
    logic acc_zero;
    logic cmp_unequal;
    logic dec_nonzero;
  } cbm_cond_s;
  typedef struct packed {
    cbm_mode_e  mode;
    logic [7:0] addr;
  } cbm_mreq_s;
  typedef struct packed {
    cbm_region_e region;
    logic [7:0]  addr;
    logic [2:0]  bit_pos;
    logic        bit_access;
  } cbm_mresp_s;
endpackage : cbm_pkg

// [cbm_core.sv]
// branch timing, operand address decode, stack pointer and stack record
`timescale 1ns/1ps
`include "cbm_defines.svh"
module cbm_core (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                instr_valid,
  output logic                     instr_ready,
  input  wire cbm_pkg::cbm_instr_s instr,
  input  wire logic [15:0]         pc_next,
  input  wire logic [7:0]          acc,
  input  wire logic [15:0]         data_pointer,
  input  wire cbm_pkg::cbm_cond_s  cond,
  output logic                     done,
  output logic                     branch_taken,
  output logic [15:0]              branch_target,
  output logic                     clear_bit,
  input  wire logic [7:0]          program_status_word,
  input  wire logic                mreq_valid,
  input  wire cbm_pkg::cbm_mreq_s  mreq,
  input  wire logic                ri_sel,
  output logic                     mresp_valid,
  output cbm_pkg::cbm_mresp_s      mresp,
  output logic [7:0]               ptr_reg_addr,
  input  wire logic                sfr_wr,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  output logic [7:0]               sfr_rdata,
  input  wire logic                xwr_valid,
  input  wire logic [15:0]         xwr_addr,
  output logic                     pmem_wr,
  output logic                     xram_wr,
  output logic                     pmem_reserved,
  output logic [7:0]               stack_pointer,
  output logic [7:0]               stack_addr,
  output logic [31:0]              stack_record,
  output logic                     stack_overflow,
  output logic                     stack_underflow
);
  ////////////////////////////////////////////////////////////////////////////
  cbm_pkg::cbm_state_e state;
  logic [2:0]          rem;
  logic [7:0]          program_store_control;
  logic [5:0]          rec_depth;
  logic                accept;
  logic                taken;
  logic [2:0]          cycles;
  logic [15:0]         target;
  logic                is_call;
  logic                is_ret;
  logic                is_push;
  logic                is_pop;
  logic [1:0]          push_n;
  logic [1:0]          pop_n;
  logic [7:0]          op;
  logic [15:0]         rel_target;
  logic [7:0]          rel;
  logic [1:0]          bank;
  logic                sp_wr;

  assign op          = instr.opcode;
  assign bank        = program_status_word[`CBM_BANK_HI_BIT:`CBM_BANK_LO_BIT];
  assign instr_ready = (state == cbm_pkg::ST_IDLE) || (rem == 3'h1);
  assign accept      = instr_valid && instr_ready;
  assign done        = (state == cbm_pkg::ST_EXEC) && (rem == 3'h1);
  assign sp_wr       = sfr_wr && (sfr_addr == `CBM_SP_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // decode: cycle count, branch decision and target of the offered instruction
  always_comb begin
    cycles  = 3'h1;
    taken   = 1'b0;
    rel     = instr.op1;
    target  = pc_next;
    is_call = 1'b0;
    is_ret  = 1'b0;
    is_push = (op == `OP_PUSH);
    is_pop  = (op == `OP_POP);
    if (op == `OP_JB || op == `OP_JNB || op == `OP_JBC || op == `OP_DECREMENT_BRANCH_NONZERO_DIR
        || op == `OP_COMPARE_BRANCH_UNEQUAL_A_DIR || op == `OP_COMPARE_BRANCH_UNEQUAL_A_IMM
        || op[7:1] == `OP_COMPARE_BRANCH_UNEQUAL_IND_HI || op[7:3] == `OP_COMPARE_BRANCH_UNEQUAL_REG_HI) begin
      rel = instr.op2; // three-byte forms carry the offset last
    end
    case (1'b1)
      (op == `OP_NOP || op == `OP_UNUSED): cycles = 3'h1;
      (op == `OP_CPL_BIT || op == `OP_ANL_C_BIT || op == `OP_ANL_C_NBIT
       || op == `OP_ORL_C_BIT || op == `OP_ORL_C_NBIT
       || op == `OP_MOV_C_BIT || op == `OP_MOV_BIT_C): cycles = 3'h2;
      (op == `OP_JC || op == `OP_JNC): begin
        taken  = cond.carry ^ (op == `OP_JNC);
        cycles = taken ? 3'h3 : 3'h2;
      end
      (op == `OP_JZ || op == `OP_JNZ): begin
        taken  = cond.acc_zero ^ (op == `OP_JNZ);
        cycles = taken ? 3'h3 : 3'h2;
      end
      (op == `OP_JB || op == `OP_JNB || op == `OP_JBC): begin
        taken  = cond.bit_val ^ (op == `OP_JNB);
        cycles = taken ? 3'h4 : 3'h3;
      end
      (op[7:1] == `OP_COMPARE_BRANCH_UNEQUAL_IND_HI): begin
        taken  = cond.cmp_unequal;
        cycles = taken ? 3'h5 : 3'h4;
      end
      (op == `OP_COMPARE_BRANCH_UNEQUAL_A_DIR || op == `OP_COMPARE_BRANCH_UNEQUAL_A_IMM
       || op[7:3] == `OP_COMPARE_BRANCH_UNEQUAL_REG_HI): begin
        taken  = cond.cmp_unequal;
        cycles = taken ? 3'h4 : 3'h3;
      end
      (op == `OP_DECREMENT_BRANCH_NONZERO_DIR): begin
        taken  = cond.dec_nonzero;
        cycles = taken ? 3'h4 : 3'h3;
      end
      (op[7:3] == `OP_DECREMENT_BRANCH_NONZERO_REG_HI): begin
        taken  = cond.dec_nonzero;
        cycles = taken ? 3'h3 : 3'h2;
      end
      (op == `OP_SHORT_JUMP): begin
        taken  = 1'b1;
        cycles = 3'h3;
      end
      (op == `OP_JMP_IND): begin
        taken  = 1'b1;
        cycles = 3'h3;
        target = data_pointer + {8'h00, acc};
      end
      (op[4:0] == `OP_ABSOLUTE_CALL_LO || op[4:0] == `OP_ABSOLUTE_JUMP_LO): begin
        taken   = 1'b1;
        cycles  = 3'h3;
        is_call = (op[4:0] == `OP_ABSOLUTE_CALL_LO);
        target  = {pc_next[15:11], op[7:5], instr.op1};
      end
      (op == `OP_LONG_CALL || op == `OP_LONG_JUMP): begin
        taken   = 1'b1;
        cycles  = 3'h4;
        is_call = (op == `OP_LONG_CALL);
        target  = {instr.op1, instr.op2};
      end
      (op == `OP_RET || op == `OP_INTERRUPT_RETURN): begin
        cycles = 3'h5;
        is_ret = 1'b1;
      end
      (is_push || is_pop): cycles = 3'h2;
      default: cycles = 3'h1;
    endcase
  end

  // displacement counts from the byte after the branch, sign extended
  assign rel_target = pc_next + {{8{rel[7]}}, rel};

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= cbm_pkg::ST_IDLE;
      rem   <= 3'h0;
    end else if (accept) begin
      state <= cbm_pkg::ST_EXEC;
      rem   <= cycles;
    end else begin
      case (state)
        cbm_pkg::ST_EXEC: begin
          rem <= rem - 3'h1;
          if (rem == 3'h1) begin
            state <= cbm_pkg::ST_IDLE;
          end
        end
        cbm_pkg::ST_IDLE: rem <= 3'h0;
        default: state <= cbm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      branch_taken  <= 1'b0;
      branch_target <= 16'h0000;
      clear_bit     <= 1'b0;
    end else begin
      clear_bit <= accept && (op == `OP_JBC) && taken;
      if (accept) begin
        branch_taken <= taken;
        if (!taken) begin
          branch_target <= pc_next;
        end else if (op == `OP_JMP_IND || is_call || op == `OP_LONG_JUMP
                     || op[4:0] == `OP_ABSOLUTE_JUMP_LO) begin
          branch_target <= target;
        end else begin
          branch_target <= rel_target;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer; a software write beats an instruction's adjustment
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_pointer <= `CBM_SP_RESET;
      stack_addr    <= 8'h00;
    end else if (sp_wr) begin
      stack_pointer <= sfr_wdata;
    end else if (accept) begin
      if (is_push || is_call) begin
        stack_addr <= stack_pointer + 8'h01;
      end else if (is_pop || is_ret) begin
        stack_addr <= stack_pointer;
      end
      // 8-bit arithmetic wraps on its own
      if (is_push) stack_pointer <= stack_pointer + 8'h01;
      if (is_call) stack_pointer <= stack_pointer + 8'h02;
      if (is_pop)  stack_pointer <= stack_pointer - 8'h01;
      if (is_ret)  stack_pointer <= stack_pointer - 8'h02;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      program_store_control <= 8'h00;
    end else if (sfr_wr && sfr_addr == `CBM_PROGRAM_STORE_CONTROL_ADDR) begin
      program_store_control <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      case (sfr_addr)
        `CBM_SP_ADDR:    sfr_rdata <= stack_pointer;
        `CBM_PROGRAM_STORE_CONTROL_ADDR: sfr_rdata <= program_store_control;
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack record; a software step of the pointer by one counts as push or pop
  always_comb begin
    push_n = 2'h0;
    pop_n  = 2'h0;
    if (sp_wr) begin
      if (sfr_wdata == stack_pointer + 8'h01) push_n = 2'h1;
      if (sfr_wdata == stack_pointer - 8'h01) pop_n  = 2'h1;
    end else if (accept) begin
      if (is_push) push_n = 2'h1;
      if (is_call) push_n = 2'h2;
      if (is_pop)  pop_n  = 2'h1;
      if (is_ret)  pop_n  = 2'h2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_record    <= 32'h0000_0000;
      rec_depth       <= 6'h00;
      stack_overflow  <= 1'b0;
      stack_underflow <= 1'b0;
    end else begin
      stack_overflow  <= 1'b0;
      stack_underflow <= 1'b0;
      if (push_n != 2'h0) begin
        // call records are 1s, data pushes 0s
        stack_record <= (push_n == 2'h2) ? {stack_record[29:0], 2'b11}
                                         : {stack_record[30:0], 1'b0};
        if (rec_depth + {4'h0, push_n} > `CBM_REC_DEPTH) begin
          stack_overflow <= 1'b1;
          rec_depth      <= `CBM_REC_DEPTH;
        end else begin
          rec_depth <= rec_depth + {4'h0, push_n};
        end
      end else if (pop_n != 2'h0) begin
        stack_record <= stack_record >> pop_n;
        if (rec_depth < {4'h0, pop_n}) begin
          stack_underflow <= 1'b1;
          rec_depth       <= 6'h00;
        end else begin
          rec_depth <= rec_depth - {4'h0, pop_n};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand address decode, one cycle of latency
  always_ff @(posedge clk) begin
    if (rst) begin
      mresp_valid  <= 1'b0;
      mresp        <= '{region: cbm_pkg::RGN_LOWER, addr: 8'h00, bit_pos: 3'h0,
                        bit_access: 1'b0};
      ptr_reg_addr <= 8'h00;
    end else begin
      mresp_valid  <= mreq_valid;
      ptr_reg_addr <= {3'h0, bank, 2'h0, ri_sel};
      if (mreq_valid) begin
        mresp.bit_access <= (mreq.mode == cbm_pkg::MODE_BIT);
        mresp.bit_pos    <= mreq.addr[2:0];
        mresp.addr       <= mreq.addr;
        case (mreq.mode)
          cbm_pkg::MODE_DIRECT:
            mresp.region <= mreq.addr[7] ? cbm_pkg::RGN_SFR : cbm_pkg::RGN_LOWER;
          cbm_pkg::MODE_INDIRECT:
            mresp.region <= mreq.addr[7] ? cbm_pkg::RGN_UPPER : cbm_pkg::RGN_LOWER;
          cbm_pkg::MODE_BANKREG: begin
            mresp.region <= cbm_pkg::RGN_LOWER;
            mresp.addr   <= {3'h0, bank, mreq.addr[2:0]};
          end
          cbm_pkg::MODE_BIT: begin
            if (mreq.addr[7]) begin
              mresp.region <= cbm_pkg::RGN_SFR;
              mresp.addr   <= {mreq.addr[7:3], 3'h0};
            end else begin
              mresp.region <= cbm_pkg::RGN_LOWER;
              mresp.addr   <= {`CBM_BIT_BYTE_BASE, mreq.addr[6:3]};
            end
          end
          default: mresp.region <= cbm_pkg::RGN_LOWER;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data-space writes go to flash only while store-enable is set
  always_ff @(posedge clk) begin
    if (rst) begin
      pmem_wr       <= 1'b0;
      xram_wr       <= 1'b0;
      pmem_reserved <= 1'b0;
    end else begin
      pmem_wr       <= xwr_valid && program_store_control[`CBM_PROGRAM_STORE_CONTROL_WE_BIT];
      xram_wr       <= xwr_valid && !program_store_control[`CBM_PROGRAM_STORE_CONTROL_WE_BIT];
      pmem_reserved <= xwr_valid && program_store_control[`CBM_PROGRAM_STORE_CONTROL_WE_BIT]
                       && (xwr_addr >= `CBM_RESERVED_BASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_nop_alias: assert property (accept && op == `OP_UNUSED |=> done)
    else $error("unused opcode not one cycle");
  a_bit_two: assert property (accept && op == `OP_CPL_BIT |=> !done ##1 done)
    else $error("bit complement not two cycles");
  a_jc_taken: assert property (accept && op == `OP_JC && cond.carry
                               |=> !done[*2] ##1 done)
    else $error("taken carry branch not three cycles");
  a_compare_branch_unequal_ind: assert property (accept && op[7:1] == `OP_COMPARE_BRANCH_UNEQUAL_IND_HI && !cond.cmp_unequal
                               |=> !done[*3] ##1 done)
    else $error("indirect compare not four cycles");
  a_decrement_branch_nonzero_dir: assert property (accept && op == `OP_DECREMENT_BRANCH_NONZERO_DIR && cond.dec_nonzero
                               |=> !done[*3] ##1 done)
    else $error("direct decrement branch not four cycles");
  a_short_jump_target: assert property (accept && op == `OP_SHORT_JUMP
      |=> branch_target == $past(pc_next) + {{8{$past(instr.op1[7])}}, $past(instr.op1)})
    else $error("short jump target wrong");
  a_page_target: assert property (accept && op[4:0] == `OP_ABSOLUTE_JUMP_LO
      |=> branch_target[15:11] == $past(pc_next[15:11]))
    else $error("page target left its page");
  a_jbc_clear: assert property (accept && op == `OP_JBC |=> clear_bit == $past(cond.bit_val))
    else $error("clearing branch mishandled bit");
  a_push_sp: assert property (accept && is_push && !sp_wr
      |=> stack_pointer == $past(stack_pointer) + 8'h01 && stack_addr == stack_pointer)
    else $error("push did not pre-increment");
  // reset is the antecedent here, so the default disable must not silence it
  a_sp_reset: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> stack_pointer == `CBM_SP_RESET)
    else $error("stack pointer reset value wrong");
  a_upper_ind: assert property (mreq_valid && mreq.mode == cbm_pkg::MODE_INDIRECT && mreq.addr[7]
      |=> mresp.region == cbm_pkg::RGN_UPPER)
    else $error("indirect high access missed upper RAM");
  a_bit_byte: assert property (mreq_valid && mreq.mode == cbm_pkg::MODE_BIT && !mreq.addr[7]
      |=> mresp.addr == 8'h20 + {4'h0, $past(mreq.addr[6:3])} && mresp.bit_access)
    else $error("bit address mapped to wrong byte");
  a_pmem_gate: assert property (xwr_valid |=> pmem_wr != xram_wr)
    else $error("data write steered to both or neither");

  c_jbc_taken: cover property (accept && op == `OP_JBC && cond.bit_val ##1 clear_bit);
  c_ret: cover property (accept && op == `OP_RET ##5 instr_ready);
  c_overflow: cover property (stack_overflow);
  c_underflow: cover property (stack_underflow);
endmodule : cbm_core

// [cbm_far_model.sv]
// far-side model: program store and debug logic watching the core's pulses
`timescale 1ns/1ps
module cbm_far_model (
  input  wire logic clk,
  input  wire logic pmem_wr,
  input  wire logic xram_wr,
  input  wire logic stack_overflow,
  input  wire logic stack_underflow,
  output int        pm_cnt,
  output int        xr_cnt,
  output int        ovf_cnt,
  output int        unf_cnt
);
  // debug logic keeps its counts across core resets, so a bench may reset the core freely
  initial begin
    pm_cnt = 0;
    xr_cnt = 0;
    ovf_cnt = 0;
    unf_cnt = 0;
  end
  always @(posedge clk) begin
    if (pmem_wr === 1'b1) pm_cnt++;
    if (xram_wr === 1'b1) xr_cnt++;
    if (stack_overflow === 1'b1) ovf_cnt++;
    if (stack_underflow === 1'b1) unf_cnt++;
  end
endmodule : cbm_far_model

// [tb.sv]
// self-checking bench for the branch timing, decode and stack record block
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [7:0]  op;
    logic [7:0]  o1;
    logic [7:0]  o2;
    logic [4:0]  c;
    int          n;
    logic        tk;
    logic [15:0] t;
    logic        cb;
  } cbm_row_s;
  logic                clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, mreq_valid = 1'b0;
  logic                ri_sel = 1'b0, sfr_wr = 1'b0, xwr_valid = 1'b0;
  cbm_pkg::cbm_instr_s instr = '0;
  cbm_pkg::cbm_cond_s  cond = '0;
  cbm_pkg::cbm_mreq_s  mreq = '0;
  logic [15:0]         pc_next = 16'h57fe, data_pointer = 16'h1234, xwr_addr = 16'h0000;
  logic [7:0]          acc = 8'hf0, program_status_word = 8'h00;
  logic [7:0]          sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic                instr_ready, done, branch_taken, clear_bit, mresp_valid;
  logic                pmem_wr, xram_wr, pmem_reserved, stack_overflow, stack_underflow;
  logic [15:0]         branch_target;
  cbm_pkg::cbm_mresp_s mresp;
  logic [7:0]          ptr_reg_addr, sfr_rdata, stack_pointer, stack_addr;
  logic [31:0]         stack_record;
  int                  error_cnt = 0, checks_done = 0, cyc = 0;
  int                  pm_cnt, xr_cnt, ovf_cnt, unf_cnt;
  cbm_row_s            push_r = '{8'hc0, 8'h30, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0};
  cbm_row_s            pop_r = '{8'hd0, 8'h30, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0};
  cbm_row_s            call_r = '{8'h12, 8'hab, 8'hcd, 5'h00, 4, 1'b1, 16'habcd, 1'b0};
  cbm_row_s            ret_r = '{8'h22, 8'h00, 8'h00, 5'h00, 5, 1'b0, 16'h57fe, 1'b0};
  // opcode, op1, op2, cond, cycles, taken, target, clear pulse
  cbm_row_s rows [29] = '{
    '{8'h00, 8'h00, 8'h00, 5'h00, 1, 1'b0, 16'h57fe, 1'b0},
    '{8'ha5, 8'h00, 8'h00, 5'h00, 1, 1'b0, 16'h57fe, 1'b0},
    '{8'hb2, 8'h21, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'h82, 8'h21, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'hb0, 8'h21, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'h72, 8'h21, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'ha0, 8'h21, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'h40, 8'hfe, 8'h00, 5'h10, 3, 1'b1, 16'h57fc, 1'b0},
    '{8'h40, 8'hfe, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'h50, 8'h7f, 8'h00, 5'h00, 3, 1'b1, 16'h587d, 1'b0},
    '{8'h20, 8'h13, 8'h80, 5'h08, 4, 1'b1, 16'h577e, 1'b0},
    '{8'h30, 8'h13, 8'h80, 5'h08, 3, 1'b0, 16'h57fe, 1'b0},
    '{8'h10, 8'h13, 8'h05, 5'h08, 4, 1'b1, 16'h5803, 1'b1},
    '{8'h10, 8'h13, 8'h05, 5'h00, 3, 1'b0, 16'h57fe, 1'b0},
    '{8'hb6, 8'h00, 8'h05, 5'h02, 5, 1'b1, 16'h5803, 1'b0},
    '{8'hb6, 8'h00, 8'h05, 5'h00, 4, 1'b0, 16'h57fe, 1'b0},
    '{8'hb4, 8'h00, 8'h05, 5'h02, 4, 1'b1, 16'h5803, 1'b0},
    '{8'hb8, 8'h00, 8'h05, 5'h00, 3, 1'b0, 16'h57fe, 1'b0},
    '{8'hd5, 8'h00, 8'h05, 5'h01, 4, 1'b1, 16'h5803, 1'b0},
    '{8'hd8, 8'h05, 8'h00, 5'h00, 2, 1'b0, 16'h57fe, 1'b0},
    '{8'hd8, 8'h05, 8'h00, 5'h01, 3, 1'b1, 16'h5803, 1'b0},
    '{8'h80, 8'h10, 8'h00, 5'h00, 3, 1'b1, 16'h580e, 1'b0},
    '{8'h73, 8'h00, 8'h00, 5'h00, 3, 1'b1, 16'h1324, 1'b0},
    '{8'he1, 8'h23, 8'h00, 5'h00, 3, 1'b1, 16'h5723, 1'b0},
    '{8'h11, 8'h45, 8'h00, 5'h00, 3, 1'b1, 16'h5045, 1'b0},
    '{8'h32, 8'h00, 8'h00, 5'h00, 5, 1'b0, 16'h57fe, 1'b0},
    '{8'h02, 8'hab, 8'hcd, 5'h00, 4, 1'b1, 16'habcd, 1'b0},
    '{8'h60, 8'h02, 8'h00, 5'h04, 3, 1'b1, 16'h5800, 1'b0},
    '{8'h70, 8'h02, 8'h00, 5'h04, 2, 1'b0, 16'h57fe, 1'b0}};

  cbm_core cbm_core_i (.clk, .rst, .instr_valid, .instr_ready, .instr, .pc_next, .acc,
    .data_pointer, .cond, .done, .branch_taken, .branch_target, .clear_bit,
    .program_status_word, .mreq_valid, .mreq, .ri_sel, .mresp_valid, .mresp, .ptr_reg_addr,
    .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata, .xwr_valid, .xwr_addr, .pmem_wr, .xram_wr,
    .pmem_reserved, .stack_pointer, .stack_addr, .stack_record, .stack_overflow,
    .stack_underflow);
  cbm_far_model cbm_far_model_i (.clk, .pmem_wr, .xram_wr, .stack_overflow, .stack_underflow,
    .pm_cnt, .xr_cnt, .ovf_cnt, .unf_cnt);

  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // a hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  // ends on an edge with the core idle again
  task automatic run_op(input cbm_row_s r);
    int n;
    instr_valid <= 1'b1;
    instr       <= {r.op, r.o1, r.o2};
    cond        <= r.c;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("clear_bit", r.cb, clear_bit);
    chk("branch_taken", r.tk, branch_taken);
    chk("branch_target", r.t, branch_target);
    for (n = 1; n < 8 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("cycles", r.n, n);
    @(posedge clk);
  endtask : run_op
  task automatic dec(input logic [1:0] m, input logic [7:0] a, input logic [2:0] rg,
                     input logic [7:0] ea, input logic [2:0] bp, input logic ba);
    mreq_valid <= 1'b1;
    mreq       <= {m, a};
    @(posedge clk);
    mreq_valid <= 1'b0;
    #1;
    chk("mresp_valid", 1, mresp_valid);
    chk("region", rg, mresp.region);
    chk("addr", ea, mresp.addr);
    chk("bit_access", ba, mresp.bit_access);
    if (m == 2'h2) begin
      chk("bit_pos", bp, mresp.bit_pos);
    end
    @(posedge clk);
  endtask : dec
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask : sfr_write
  task automatic xw(input logic [15:0] a, input logic pm, input logic xr, input logic rs);
    xwr_valid <= 1'b1;
    xwr_addr  <= a;
    @(posedge clk);
    xwr_valid <= 1'b0;
    #1;
    chk("pmem_wr", pm, pmem_wr);
    chk("xram_wr", xr, xram_wr);
    chk("pmem_reserved", rs, pmem_reserved);
    @(posedge clk);
  endtask : xw
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset;
    chk("stack_pointer", 8'h07, stack_pointer);
    chk("stack_record", 0, stack_record);
    foreach (rows[i]) run_op(rows[i]);
    dec(2'h0, 8'h45, 3'b001, 8'h45, 0, 0);
    dec(2'h0, 8'h90, 3'b100, 8'h90, 0, 0);
    dec(2'h1, 8'h90, 3'b010, 8'h90, 0, 0);
    dec(2'h2, 8'h13, 3'b001, 8'h22, 3, 1);
    dec(2'h2, 8'h7f, 3'b001, 8'h2f, 7, 1);
    dec(2'h2, 8'h88, 3'b100, 8'h88, 0, 1);
    program_status_word <= 8'h10;
    ri_sel              <= 1'b1;
    dec(2'h3, 8'h05, 3'b001, 8'h15, 0, 0);
    chk("ptr_reg_addr", 8'h11, ptr_reg_addr);
    sfr_write(8'h81, 8'hfe);
    #1;
    chk("sfr_rdata", 8'hfe, sfr_rdata);
    @(posedge clk);
    run_op(push_r);
    chk("stack_addr", 8'hff, stack_addr);
    run_op(push_r);
    chk("stack_pointer", 8'h00, stack_pointer);
    chk("stack_addr", 8'h00, stack_addr);
    run_op(pop_r);
    chk("stack_pointer", 8'hff, stack_pointer);
    do_reset;
    run_op(call_r);
    chk("stack_pointer", 8'h09, stack_pointer);
    chk("stack_record", 32'h3, stack_record);
    run_op(ret_r);
    chk("stack_record", 0, stack_record);
    run_op(ret_r);
    chk("underflows", 1, unf_cnt);
    do_reset;
    repeat (16) run_op(call_r);
    chk("stack_record", 32'hffffffff, stack_record);
    chk("overflows", 0, ovf_cnt);
    run_op(push_r);
    chk("overflows", 1, ovf_cnt);
    xw(16'h1000, 1'b0, 1'b1, 1'b0);
    sfr_write(8'h8f, 8'h01);
    xw(16'h1000, 1'b1, 1'b0, 1'b0);
    xw(16'hee00, 1'b1, 1'b0, 1'b1);
    #1;
    chk("flash writes", 2, pm_cnt);
    finish_test;
  end
endmodule : tb
